// [hw/cfgio_pkg.sv]
package cfgio_pkg;

    // Register offsets inside the port register window
    localparam int OFS_W = 5;
    localparam logic [OFS_W-1:0] OFS_PIN_A = 5'h02;
    localparam logic [OFS_W-1:0] OFS_PIN_B = 5'h03;
    localparam logic [OFS_W-1:0] OFS_DIR_A = 5'h04;
    localparam logic [OFS_W-1:0] OFS_DIR_B = 5'h05;
    localparam logic [OFS_W-1:0] OFS_DAT_A = 5'h06;
    localparam logic [OFS_W-1:0] OFS_DAT_B = 5'h07;
    localparam logic [OFS_W-1:0] OFS_PAGE = 5'h18;
    localparam logic [OFS_W-1:0] OFS_EVEN_MASK = 5'h1e;

    // Widths and reset values
    localparam int PAGE_W = 4;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] DAT_RST = 8'h00;
    localparam logic [PAGE_W-1:0] PAGE_RST = 4'h0;

    // Bit positions in the synchronised pin vector
    localparam int SY_ALE = 0;
    localparam int SY_RD = 1;
    localparam int SY_WR = 2;
    localparam int SY_BHE = 3;
    localparam int SY_A19 = 4;
    localparam int SY_AD = 5;
    localparam int SY_AHI = 13;
    localparam int SY_PA = 21;
    localparam int SY_PB = 29;
    localparam int SY_PC = 37;
    localparam int SY_RDIN = 40;
    localparam int SY_ADOUT = 41;
    localparam int SY_WROUT = 42;
    localparam int SY_SEL = 43;
    localparam int SY_PT = 44;
    localparam int PT_N = 27;
    localparam int SY_W = 71;

    // Product term layout: four per select 0..3, two per 4..7, one per 8..10
    localparam int PT_CS4 = 16;
    localparam int PT_CS8 = 24;

endpackage : cfgio_pkg

// [hw/cfgio_ports.sv]
`timescale 1ns/1ps
module cfgio_ports (
    input wire logic clk,
    input wire logic rst_n,
    // Static configuration
    input wire logic mux_mode,
    input wire logic wide_bus,
    input wire logic strobe_mode,
    input wire logic low_address_latch_mode,
    input wire logic high_address_latch_mode,
    input wire logic [7:0] port_a_function_bits,
    input wire logic port_a_follow_mode,
    input wire logic [7:0] port_a_driver_type_select,
    input wire logic [7:0] port_b_function_bits,
    input wire logic [7:0] port_b_driver_type_select,
    input wire logic [2:0] port_c_function_bits,
    input wire logic [3:0] port_c_input_kind_bits,
    // Host bus pins
    input wire logic ale,
    input wire logic rd_e,
    input wire logic wr_rw,
    input wire logic byte_high_enable_n,
    input wire logic [7:0] low_muxed_bus_pins_in,
    input wire logic [7:0] high_address_pins_in,
    input wire logic a19_in,
    // Decoder array terms
    input wire logic read_in_window,
    input wire logic address_out_window,
    input wire logic write_out_window,
    input wire logic port_register_base_select,
    input wire logic [26:0] product_terms,
    // Port pins and low bus pin outputs
    input wire logic [7:0] port_a_pins_in,
    input wire logic [7:0] port_b_pins_in,
    input wire logic [2:0] port_c_pins_in,
    output logic [7:0] low_muxed_bus_pins_out_q,
    output logic [7:0] low_muxed_bus_pins_oe_q,
    output logic [7:0] port_a_pins_out_q,
    output logic [7:0] port_a_pins_oe_q,
    output logic [7:0] port_b_pins_out_q,
    output logic [7:0] port_b_pins_oe_q,
    output logic [2:0] port_c_pins_out_q,
    output logic [2:0] port_c_pins_oe_q,
    // Toward the decoder arrays
    output logic [3:0] memory_page_select_q,
    output logic [15:0] decoder_address_q,
    output logic [3:0] decoder_high_address_q,
    output logic [3:0] decoder_high_logic_q,
    output logic decoder_ale_logic_q
);

    localparam int W = cfgio_pkg::SY_W;

    function automatic logic b_hit(
        input logic [cfgio_pkg::OFS_W-1:0] off,
        input logic [cfgio_pkg::OFS_W-1:0] ofs_a,
        input logic wide,
        input logic bhe_n
    );
        if (wide) begin
            b_hit = ((off & cfgio_pkg::OFS_EVEN_MASK) == ofs_a) && !bhe_n;
        end else begin
            b_hit = (off == (ofs_a | 5'h01));
        end
    endfunction : b_hit

    // Returns {oe, out} for one general I/O pin
    function automatic logic [1:0] gpio_pin(
        input logic dir,
        input logic dat,
        input logic od
    );
        gpio_pin[1] = dir && (!od || !dat);
        gpio_pin[0] = od ? 1'b0 : dat;
    endfunction : gpio_pin

    logic [W-1:0] sy_in, s1_q, s2_q, s3_q, st_q;

    assign sy_in = {product_terms, port_register_base_select,
                    write_out_window, address_out_window, read_in_window,
                    port_c_pins_in, port_b_pins_in, port_a_pins_in,
                    high_address_pins_in, low_muxed_bus_pins_in, a19_in,
                    byte_high_enable_n, wr_rw, rd_e, ale};

    // Three-stage pin sampling; a level counts once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            st_q <= '0;
        end else begin
            s1_q <= sy_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            st_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & st_q);
        end
    end

    logic ale_s, rd_act, wr_act, bhe_n_s, sel_s;
    logic [7:0] ad_s, ahi_s, pa_s, pb_s;
    logic [3:0] hc_s;
    logic [cfgio_pkg::PT_N-1:0] pt_s;

    assign ale_s = st_q[cfgio_pkg::SY_ALE];
    assign bhe_n_s = st_q[cfgio_pkg::SY_BHE];
    assign sel_s = st_q[cfgio_pkg::SY_SEL];
    assign ad_s = st_q[cfgio_pkg::SY_AD +: 8];
    assign ahi_s = st_q[cfgio_pkg::SY_AHI +: 8];
    assign pa_s = st_q[cfgio_pkg::SY_PA +: 8];
    assign pb_s = st_q[cfgio_pkg::SY_PB +: 8];
    assign hc_s = {st_q[cfgio_pkg::SY_A19], st_q[cfgio_pkg::SY_PC +: 3]};
    assign pt_s = st_q[cfgio_pkg::SY_PT +: cfgio_pkg::PT_N];

    assign rd_act = strobe_mode ?
        (st_q[cfgio_pkg::SY_RD] && st_q[cfgio_pkg::SY_WR]) :
        !st_q[cfgio_pkg::SY_RD];
    assign wr_act = strobe_mode ?
        (st_q[cfgio_pkg::SY_RD] && !st_q[cfgio_pkg::SY_WR]) :
        !st_q[cfgio_pkg::SY_WR];

    logic ale_p_q, ale_fall, alat_bhe_n_q;
    logic [7:0] alat_lo_q, alat_hi_q;
    logic [3:0] alat_hc_q;

    assign ale_fall = ale_p_q && !ale_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ale_p_q <= 1'b0;
            alat_lo_q <= 8'h00;
            alat_hi_q <= 8'h00;
            alat_bhe_n_q <= 1'b1;
            alat_hc_q <= 4'h0;
        end else begin
            ale_p_q <= ale_s;
            if (ale_fall) begin
                alat_lo_q <= ad_s;
                alat_hi_q <= ahi_s;
                alat_bhe_n_q <= bhe_n_s;
                alat_hc_q <= hc_s;
            end
        end
    end

    logic sep_latched, bhe_n_cur;
    logic [7:0] addr_lo, addr_hi;
    logic [cfgio_pkg::OFS_W-1:0] off;

    assign sep_latched = !mux_mode && low_address_latch_mode;
    assign addr_lo = (mux_mode || sep_latched) ? alat_lo_q : ad_s;
    assign addr_hi = sep_latched ? alat_hi_q : ahi_s;
    assign bhe_n_cur = mux_mode ? alat_bhe_n_q : bhe_n_s;
    assign off = addr_lo[cfgio_pkg::OFS_W-1:0];

    // Write capture during the strobe, commit at its end
    logic wr_p_q, wcap_q, wbhe_n_q, commit;
    logic [7:0] wlo_q, whi_q;
    logic [cfgio_pkg::OFS_W-1:0] woff_q;

    assign commit = wr_p_q && !wr_act && wcap_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_p_q <= 1'b0;
            wcap_q <= 1'b0;
            wlo_q <= 8'h00;
            whi_q <= 8'h00;
            woff_q <= '0;
            wbhe_n_q <= 1'b1;
        end else begin
            wr_p_q <= wr_act;
            if (wr_act && sel_s) begin
                wcap_q <= 1'b1;
                wlo_q <= mux_mode ? ad_s : pa_s;
                whi_q <= pb_s;
                woff_q <= off;
                wbhe_n_q <= bhe_n_cur;
            end else if (!wr_act) begin
                wcap_q <= 1'b0;
            end
        end
    end

    logic [7:0] dir_a_q, dir_b_q, dat_a_q, dat_b_q, wb_data;

    assign wb_data = wide_bus ? whi_q : wlo_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_a_q <= cfgio_pkg::DIR_RST;
            dir_b_q <= cfgio_pkg::DIR_RST;
        end else if (commit) begin
            if (woff_q == cfgio_pkg::OFS_DIR_A) begin
                dir_a_q <= wlo_q;
            end
            if (b_hit(woff_q, cfgio_pkg::OFS_DIR_A, wide_bus, wbhe_n_q)) begin
                dir_b_q <= wb_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dat_a_q <= cfgio_pkg::DAT_RST;
            dat_b_q <= cfgio_pkg::DAT_RST;
        end else if (commit) begin
            if (woff_q == cfgio_pkg::OFS_DAT_A) begin
                dat_a_q <= wlo_q;
            end
            if (b_hit(woff_q, cfgio_pkg::OFS_DAT_A, wide_bus, wbhe_n_q)) begin
                dat_b_q <= wb_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memory_page_select_q <= cfgio_pkg::PAGE_RST;
        end else if (commit && woff_q == cfgio_pkg::OFS_PAGE) begin
            memory_page_select_q <= wlo_q[cfgio_pkg::PAGE_W-1:0];
        end
    end

    // Register read data; pin registers have no write path
    logic [7:0] rd_lo, rd_hi;
    logic rd_hit, rd_drive, bh_pin, bh_dir, bh_dat;

    always_comb begin
        bh_pin = b_hit(off, cfgio_pkg::OFS_PIN_A, wide_bus, bhe_n_cur);
        bh_dir = b_hit(off, cfgio_pkg::OFS_DIR_A, wide_bus, bhe_n_cur);
        bh_dat = b_hit(off, cfgio_pkg::OFS_DAT_A, wide_bus, bhe_n_cur);
        rd_lo = 8'h00;
        rd_hi = 8'h00;
        rd_hit = 1'b1;
        if (off == cfgio_pkg::OFS_PIN_A) begin
            rd_lo = pa_s;
        end else if (off == cfgio_pkg::OFS_DIR_A) begin
            rd_lo = dir_a_q;
        end else if (off == cfgio_pkg::OFS_DAT_A) begin
            rd_lo = dat_a_q;
        end else if (off == cfgio_pkg::OFS_PAGE) begin
            rd_lo = {4'h0, memory_page_select_q};
        end else if (wide_bus) begin
            rd_hit = 1'b0;
        end else if (bh_pin) begin
            rd_lo = pb_s;
        end else if (bh_dir) begin
            rd_lo = dir_b_q;
        end else if (bh_dat) begin
            rd_lo = dat_b_q;
        end else begin
            rd_hit = 1'b0;
        end
        if (wide_bus) begin
            if (bh_pin) begin
                rd_hi = pb_s;
            end else if (bh_dir) begin
                rd_hi = dir_b_q;
            end else if (bh_dat) begin
                rd_hi = dat_b_q;
            end
            rd_hit = rd_hit || bh_pin || bh_dir || bh_dat;
        end
        rd_drive = rd_act && sel_s && rd_hit;
    end

    logic [10:0] cs;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cs[i] = |pt_s[4*i +: 4];
        end
        for (int i = 0; i < 4; i++) begin
            cs[4+i] = |pt_s[cfgio_pkg::PT_CS4 + 2*i +: 2];
        end
        for (int i = 0; i < 3; i++) begin
            cs[8+i] = pt_s[cfgio_pkg::PT_CS8 + i];
        end
    end

    logic trk_ao, trk_wo, trk_ri;
    logic [7:0] pa_out_d, pa_oe_d, pb_out_d, pb_oe_d, ad_out_d, ad_oe_d;
    logic [1:0] ga, gb;

    assign trk_ao = st_q[cfgio_pkg::SY_ADOUT] && ale_s;
    assign trk_wo = st_q[cfgio_pkg::SY_WROUT] && wr_act;
    assign trk_ri = st_q[cfgio_pkg::SY_RDIN] && rd_act;

    always_comb begin
        pa_out_d = 8'h00;
        pa_oe_d = 8'h00;
        ad_out_d = rd_lo;
        ad_oe_d = (mux_mode && rd_drive) ? 8'hff : 8'h00;
        ga = 2'b00;
        if (!mux_mode) begin
            pa_out_d = rd_lo;
            pa_oe_d = rd_drive ? 8'hff : 8'h00;
        end else if (port_a_follow_mode) begin
            pa_out_d = ad_s;
            if (trk_ao || trk_wo) begin
                pa_oe_d = 8'hff;
            end else if (trk_ri && !rd_drive) begin
                ad_out_d = pa_s;
                ad_oe_d = 8'hff;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                ga = gpio_pin(dir_a_q[i], dat_a_q[i],
                             port_a_driver_type_select[i]);
                if (port_a_function_bits[i]) begin
                    pa_out_d[i] = alat_lo_q[i];
                    pa_oe_d[i] = 1'b1;
                end else begin
                    pa_out_d[i] = ga[0];
                    pa_oe_d[i] = ga[1];
                end
            end
        end
    end

    always_comb begin
        pb_out_d = 8'h00;
        pb_oe_d = 8'h00;
        gb = 2'b00;
        if (!mux_mode && wide_bus) begin
            pb_out_d = rd_hi;
            pb_oe_d = rd_drive ? 8'hff : 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                gb = gpio_pin(dir_b_q[i], dat_b_q[i],
                             port_b_driver_type_select[i]);
                if (port_b_function_bits[i]) begin
                    pb_out_d[i] = gb[0];
                    pb_oe_d[i] = gb[1];
                end else begin
                    pb_out_d[i] = !cs[i];
                    pb_oe_d[i] = 1'b1;
                end
            end
        end
    end

    logic [3:0] hc_val, hc_in_mask;

    assign hc_val = high_address_latch_mode ? alat_hc_q : hc_s;
    assign hc_in_mask = {1'b1, ~port_c_function_bits};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_muxed_bus_pins_out_q <= 8'h00;
            low_muxed_bus_pins_oe_q <= 8'h00;
            port_a_pins_out_q <= 8'h00;
            port_a_pins_oe_q <= 8'h00;
            port_b_pins_out_q <= 8'h00;
            port_b_pins_oe_q <= 8'h00;
            port_c_pins_out_q <= 3'h0;
            port_c_pins_oe_q <= 3'h0;
        end else begin
            low_muxed_bus_pins_out_q <= ad_out_d;
            low_muxed_bus_pins_oe_q <= ad_oe_d;
            port_a_pins_out_q <= pa_out_d;
            port_a_pins_oe_q <= pa_oe_d;
            port_b_pins_out_q <= pb_out_d;
            port_b_pins_oe_q <= pb_oe_d;
            port_c_pins_out_q <= ~cs[10:8];
            port_c_pins_oe_q <= port_c_function_bits;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            decoder_address_q <= 16'h0000;
            decoder_high_address_q <= 4'h0;
            decoder_high_logic_q <= 4'h0;
            decoder_ale_logic_q <= 1'b0;
        end else begin
            decoder_address_q <= {addr_hi, addr_lo};
            decoder_high_address_q <=
                hc_val & hc_in_mask & port_c_input_kind_bits;
            decoder_high_logic_q <=
                hc_val & hc_in_mask & ~port_c_input_kind_bits;
            decoder_ale_logic_q <=
                !mux_mode && !low_address_latch_mode && ale_s;
        end
    end

endmodule : cfgio_ports

// [verif/cfgio_host.sv]
`timescale 1ns/1ps
module cfgio_host (
    input wire logic clk,
    input wire logic strobe_mode,
    input wire logic [7:0] bus_wire,
    output logic ale,
    output logic rd_e,
    output logic wr_rw,
    output logic sel,
    output logic [7:0] ad_q
);
    // Requests active high; pins follow the strobe mode
    task automatic drive(input logic a, input logic r, input logic w,
            input logic s, input logic [7:0] d);
        ale = a;
        rd_e = (strobe_mode === 1'b1) ? (r || w) : !r;
        wr_rw = !w;
        sel = s;
        ad_q = d;
    endtask : drive

    // Released bus shows the inverse of the offset
    task automatic cyc(input logic [4:0] off, input logic wr,
            input logic [7:0] wd, output logic [7:0] rdat);
        drive(1'b1, 1'b0, 1'b0, 1'b1, {3'h0, off});
        repeat (5) @(negedge clk);
        drive(1'b0, 1'b0, 1'b0, 1'b1, {3'h0, off});
        repeat (4) @(negedge clk);
        drive(1'b0, !wr, wr, 1'b1, wr ? wd : ~{3'h0, off});
        repeat (8) @(negedge clk);
        rdat = bus_wire;
        drive(1'b0, 1'b0, 1'b0, 1'b1, wr ? wd : ~{3'h0, off});
        repeat (6) @(negedge clk);
        drive(1'b0, 1'b0, 1'b0, 1'b0, ~{3'h0, off});
        repeat (4) @(negedge clk);
    endtask : cyc

    initial drive(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
endmodule : cfgio_host

// [verif/cfgio_ports_asserts.sv]
`timescale 1ns/1ps
module cfgio_ports_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mux_mode,
    input wire logic wide_bus,
    input wire logic strobe_mode,
    input wire logic [7:0] port_a_function_bits,
    input wire logic port_a_follow_mode,
    input wire logic [7:0] port_a_driver_type_select,
    input wire logic [7:0] port_b_function_bits,
    input wire logic [7:0] port_b_driver_type_select,
    input wire logic [2:0] port_c_function_bits,
    input wire logic ale,
    input wire logic rd_e,
    input wire logic wr_rw,
    input wire logic [7:0] low_muxed_bus_pins_in,
    input wire logic read_in_window,
    input wire logic address_out_window,
    input wire logic write_out_window,
    input wire logic port_register_base_select,
    input wire logic [26:0] product_terms,
    input wire logic [7:0] port_a_pins_in,
    input wire logic [7:0] low_muxed_bus_pins_out_q,
    input wire logic [7:0] low_muxed_bus_pins_oe_q,
    input wire logic [7:0] port_a_pins_out_q,
    input wire logic [7:0] port_a_pins_oe_q,
    input wire logic [7:0] port_b_pins_out_q,
    input wire logic [7:0] port_b_pins_oe_q,
    input wire logic [2:0] port_c_pins_out_q,
    input wire logic [2:0] port_c_pins_oe_q
);
    logic [3:0] up_q;
    logic [10:0] cs_v;
    wire logic gp = mux_mode && !port_a_follow_mode;
    wire logic fol = mux_mode && port_a_follow_mode;
    wire logic wr_act = strobe_mode ? (rd_e && !wr_rw) : !wr_rw;
    wire logic rd_act = strobe_mode ? (rd_e && wr_rw) : !rd_e;
    wire logic ready = (up_q == 4'hf);

    // Waits for the synchronisers to refill
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 4'h0;
        end else if (!ready) begin
            up_q <= up_q + 4'h1;
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) cs_v[i] = |product_terms[4*i +: 4];
        for (int i = 0; i < 4; i++) cs_v[4+i] = |product_terms[16+2*i +: 2];
        cs_v[10:8] = product_terms[26:24];
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_addr_set;
        (ale && $stable(low_muxed_bus_pins_in))[*4];
    endsequence
    sequence s_addr_held;
        (!ale && $stable(low_muxed_bus_pins_in))[*4] ##1 (!ale)[*4];
    endsequence

    a_addr_latch: assert property (
        ready && gp ##0 s_addr_set ##1 s_addr_held |->
        ((port_a_pins_out_q ^ $past(low_muxed_bus_pins_in, 5))
        & port_a_function_bits & ~port_a_driver_type_select) == 8'h00)
        else $error("port a latched address wrong");
    a_od_low: assert property (
        gp |-> (port_a_pins_oe_q & port_a_pins_out_q
        & port_a_driver_type_select & ~port_a_function_bits) == 8'h00)
        else $error("open drain pin driven high");
    a_cs_low: assert property (
        ready && (mux_mode || !wide_bus) ##0 ($stable(product_terms))[*8]
        |-> ((port_b_pins_out_q ^ ~cs_v[7:0]) & ~port_b_function_bits
        & ~port_b_driver_type_select) == 8'h00)
        else $error("port b chip select wrong");
    a_cs_high: assert property (
        ready ##0 ($stable(product_terms))[*8] |->
        ((port_c_pins_out_q ^ ~cs_v[10:8]) & port_c_function_bits) == 3'h0
        && (port_c_pins_oe_q & port_c_function_bits) == port_c_function_bits)
        else $error("port c chip select wrong");
    a_follow_float: assert property (
        (ready && fol && !address_out_window && !write_out_window
        && !read_in_window)[*8] |-> port_a_pins_oe_q == 8'h00)
        else $error("follow mode port a not floating");
    a_follow_addr: assert property (
        (ready && fol && address_out_window && ale
        && $stable(low_muxed_bus_pins_in))[*8] |-> port_a_pins_oe_q == 8'hff
        && port_a_pins_out_q == low_muxed_bus_pins_in)
        else $error("follow mode address not passed");
    a_follow_write: assert property (
        (ready && fol && write_out_window && wr_act && !ale
        && $stable(low_muxed_bus_pins_in))[*8] |-> port_a_pins_oe_q == 8'hff
        && port_a_pins_out_q == low_muxed_bus_pins_in)
        else $error("follow mode write data not passed");
    a_follow_read: assert property (
        (ready && fol && read_in_window && rd_act && !ale
        && !port_register_base_select && $stable(port_a_pins_in))[*8]
        |-> low_muxed_bus_pins_oe_q == 8'hff
        && low_muxed_bus_pins_out_q == port_a_pins_in)
        else $error("follow mode read data not passed");
endmodule : cfgio_ports_asserts

// [verif/tb_cfgio_ports.sv]
`timescale 1ns/1ps
module tb_cfgio_ports;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mux_mode = 1'b1;
    logic wide_bus = 1'b0;
    logic strobe_mode = 1'b0;
    logic low_address_latch_mode = 1'b0;
    logic high_address_latch_mode = 1'b0;
    logic [7:0] port_a_function_bits = 8'hf0;
    logic port_a_follow_mode = 1'b0;
    logic [7:0] port_a_driver_type_select = 8'h03;
    logic [7:0] port_b_function_bits = 8'h00;
    logic [7:0] port_b_driver_type_select = 8'h00;
    logic [2:0] port_c_function_bits = 3'h7;
    logic [3:0] port_c_input_kind_bits = 4'h0;
    logic byte_high_enable_n = 1'b1;
    logic [7:0] high_address_pins_in = 8'h00;
    logic a19_in = 1'b0;
    logic read_in_window = 1'b0;
    logic address_out_window = 1'b0;
    logic write_out_window = 1'b0;
    logic [26:0] product_terms = 27'h0;
    logic [7:0] pa_ext = 8'h5a;
    logic ale, rd_e, wr_rw, port_register_base_select, dal;
    logic [7:0] host_ad, low_muxed_bus_pins_in, port_a_pins_in;
    logic [7:0] port_b_pins_in, rv;
    logic [2:0] port_c_pins_in, port_c_pins_out_q, port_c_pins_oe_q;
    logic [7:0] low_muxed_bus_pins_out_q, low_muxed_bus_pins_oe_q;
    logic [7:0] port_a_pins_out_q, port_a_pins_oe_q;
    logic [7:0] port_b_pins_out_q, port_b_pins_oe_q;
    logic [3:0] memory_page_select_q, dec_ha, dec_hl;
    logic [15:0] dec_a;
    logic [10:0] e;
    int k;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    function automatic logic [7:0] res(input logic [7:0] oe,
            input logic [7:0] o, input logic [7:0] x);
        return (oe & o) | (~oe & x);
    endfunction : res

    assign low_muxed_bus_pins_in = res(low_muxed_bus_pins_oe_q,
        low_muxed_bus_pins_out_q, host_ad);
    assign port_a_pins_in = res(port_a_pins_oe_q, port_a_pins_out_q, pa_ext);
    assign port_b_pins_in = res(port_b_pins_oe_q, port_b_pins_out_q, 8'hc3);
    assign port_c_pins_in = (port_c_pins_oe_q & port_c_pins_out_q)
        | (~port_c_pins_oe_q & 3'h5);

    cfgio_host u_cfgio_host (.clk, .strobe_mode,
        .bus_wire(low_muxed_bus_pins_in), .ale, .rd_e, .wr_rw,
        .sel(port_register_base_select), .ad_q(host_ad));

    cfgio_ports u_cfgio_ports (.clk, .rst_n, .mux_mode, .wide_bus,
        .strobe_mode, .low_address_latch_mode, .high_address_latch_mode,
        .port_a_function_bits, .port_a_follow_mode,
        .port_a_driver_type_select, .port_b_function_bits,
        .port_b_driver_type_select, .port_c_function_bits,
        .port_c_input_kind_bits, .ale, .rd_e, .wr_rw, .byte_high_enable_n,
        .low_muxed_bus_pins_in, .high_address_pins_in, .a19_in,
        .read_in_window, .address_out_window, .write_out_window,
        .port_register_base_select, .product_terms, .port_a_pins_in,
        .port_b_pins_in, .port_c_pins_in, .low_muxed_bus_pins_out_q,
        .low_muxed_bus_pins_oe_q, .port_a_pins_out_q, .port_a_pins_oe_q,
        .port_b_pins_out_q, .port_b_pins_oe_q, .port_c_pins_out_q,
        .port_c_pins_oe_q, .memory_page_select_q,
        .decoder_address_q(dec_a), .decoder_high_address_q(dec_ha),
        .decoder_high_logic_q(dec_hl), .decoder_ale_logic_q(dal));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
            input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got,
                exp);
        end
    endtask : chk

    task automatic rd(input logic [4:0] off, input logic [7:0] exp,
            input string what);
        u_cfgio_host.cyc(off, 1'b0, 8'h00, rv);
        chk(rv, exp, what);
    endtask : rd

    task automatic wr(input logic [4:0] off, input logic [7:0] d);
        u_cfgio_host.cyc(off, 1'b1, d, rv);
    endtask : wr

    task automatic test_done;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            $display("mismatch at %0t: timeout", $time);
            test_done();
        end
    end

    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        rd(5'h04, 8'h00, "dir a reset");
        rd(5'h05, 8'h00, "dir b reset");
        chk(port_a_pins_oe_q & 8'h0f, 8'h00, "pa oe reset");
        wr(5'h04, 8'hff);
        wr(5'h06, 8'h05);
        rd(5'h04, 8'hff, "dir a");
        rd(5'h06, 8'h05, "data a");
        chk({4'h0, port_a_pins_oe_q[3:0]}, 8'h0e, "pa oe");
        chk({4'h0, port_a_pins_out_q[3:0] & 4'he}, 8'h04, "pa out");
        rd(5'h02, 8'h04, "pin a");
        rd(5'h03, 8'hff, "pin b");
        wr(5'h05, 8'h3c);
        rd(5'h05, 8'h3c, "dir b");
        wr(5'h02, 8'h33);
        rd(5'h04, 8'hff, "pin reg write");
        wr(5'h18, 8'h09);
        chk({4'h0, memory_page_select_q}, 8'h09, "page out");
        chk({port_a_pins_oe_q[7:4], port_a_pins_out_q[7:4]}, 8'hf1,
            "adr");
        rd(5'h18, 8'h09, "page read");
        wr(5'h04, 8'h00);
        chk({4'h0, port_a_pins_oe_q[3:0]}, 8'h00, "pa input");
        for (int t = 0; t < 27; t++) begin
            k = t < 16 ? t / 4 : (t < 24 ? 4 + (t - 16) / 2 : t - 16);
            product_terms = 27'h1 << t;
            repeat (12) @(negedge clk);
            e = ~(11'h1 << k);
            chk(port_b_pins_out_q, e[7:0], "cs low");
            chk({5'h0, port_c_pins_out_q}, {5'h0, e[10:8]}, "cs high");
        end
        chk(port_b_pins_oe_q, 8'hff, "cs oe");
        // Follow mode, strobe and port C decoder inputs
        rst_n = 1'b0;
        port_a_follow_mode = 1'b1;
        strobe_mode = 1'b1;
        wide_bus = 1'b1;
        high_address_latch_mode = 1'b1;
        low_address_latch_mode = 1'b1;
        port_c_function_bits = 3'h0;
        port_c_input_kind_bits = 4'h5;
        port_b_driver_type_select = 8'hff;
        high_address_pins_in = 8'h12;
        a19_in = 1'b1;
        product_terms = 27'h0;
        pa_ext = 8'hc3;
        u_cfgio_host.drive(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (12) @(negedge clk);
        chk(port_a_pins_oe_q, 8'h00, "follow idle");
        address_out_window = 1'b1;
        u_cfgio_host.drive(1'b1, 1'b0, 1'b0, 1'b0, 8'h3c);
        repeat (12) @(negedge clk);
        chk(port_a_pins_in, 8'h3c, "follow addr");
        u_cfgio_host.drive(1'b0, 1'b0, 1'b0, 1'b0, 8'h3c);
        address_out_window = 1'b0;
        write_out_window = 1'b1;
        repeat (12) @(negedge clk);
        chk(port_a_pins_in, 8'hc3, "window no strobe");
        chk({dec_ha, dec_hl}, 8'h58, "pc inputs");
        chk(dec_a[7:0], 8'h3c, "addr lo");
        chk(dec_a[15:8] | {dal, 7'h00}, 8'h12, "addr hi");
        u_cfgio_host.drive(1'b0, 1'b0, 1'b1, 1'b0, 8'h3c);
        repeat (12) @(negedge clk);
        chk(port_a_pins_in, 8'h3c, "follow write");
        u_cfgio_host.drive(1'b0, 1'b1, 1'b0, 1'b0, 8'h99);
        write_out_window = 1'b0;
        read_in_window = 1'b1;
        pa_ext = 8'h66;
        repeat (12) @(negedge clk);
        chk(low_muxed_bus_pins_in, 8'h66, "follow read");
        u_cfgio_host.drive(1'b0, 1'b0, 1'b0, 1'b0, 8'h99);
        read_in_window = 1'b0;
        repeat (12) @(negedge clk);
        chk(low_muxed_bus_pins_in, 8'h99, "bus released");
        chk(port_a_pins_oe_q, 8'h00, "follow float");
        test_done();
    end
endmodule : tb_cfgio_ports

bind cfgio_ports cfgio_ports_asserts u_chk (.clk, .rst_n, .mux_mode,
    .wide_bus, .strobe_mode, .port_a_function_bits, .port_a_follow_mode,
    .port_a_driver_type_select, .port_b_function_bits,
    .port_b_driver_type_select, .port_c_function_bits, .ale, .rd_e, .wr_rw,
    .low_muxed_bus_pins_in, .read_in_window, .address_out_window,
    .write_out_window, .port_register_base_select, .product_terms,
    .port_a_pins_in, .low_muxed_bus_pins_out_q, .low_muxed_bus_pins_oe_q,
    .port_a_pins_out_q, .port_a_pins_oe_q, .port_b_pins_out_q,
    .port_b_pins_oe_q, .port_c_pins_out_q, .port_c_pins_oe_q);
